// ===== core/ubg_defines.svh
`ifndef UBG_DEFINES_SVH
`define UBG_DEFINES_SVH

// ==========================================
// Register map (byte addresses)
`define UBG_ADDR_PRESCALER   12'h000
`define UBG_ADDR_START       12'h004
`define UBG_ADDR_STOP        12'h008
`define UBG_ADDR_ENABLE      12'h00C
`define UBG_ADDR_MODE0       12'h010
`define UBG_ADDR_MODE1       12'h014
`define UBG_ADDR_DATA0       12'h018
`define UBG_ADDR_DATA1       12'h01C
`define UBG_ADDR_STATUS      12'h020

// ==========================================
// Field positions
`define UBG_PRS_LOW_LSB      0
`define UBG_PRS_HIGH_LSB     4
`define UBG_PRS_WIDTH        4
`define UBG_CKS_BIT          15
`define UBG_DIV_MSB          15
`define UBG_DIV_LSB          9

// ==========================================
// Reset values and minimum divider
`define UBG_RST_PRESCALER    8'h00
`define UBG_RST_MODE         16'h0020
`define UBG_RST_DATA         16'h0000
`define UBG_DIV_MIN          7'h02

`endif

// ===== core/ubg_pkg.sv
package ubg_pkg;
	typedef enum logic [1:0] {
		UBG_IDLE,
		UBG_RUN
	} ubg_state_t;
endpackage : ubg_pkg

// ===== core/ubg_prescaler.sv
`timescale 1ns/10ps
`include "ubg_defines.svh"

// ==========================================
// Free-running power-of-two enables
module ubg_prescaler #(
	parameter int STAGES = 16
) (
	input  wire logic              clock,
	input  wire logic              reset_n,
	output logic [STAGES-1:0]      tick
);
	logic [STAGES-2:0] count;
	logic [STAGES-2:0] next_count;
	logic [STAGES-1:0] next_tick;

	if (STAGES < 2) begin : g_bad_stages
		$error("ubg_prescaler: STAGES must be at least 2");
	end

	// Running AND of low count bits; a variable part-select would not elaborate
	always_comb begin
		logic carry;
		carry        = 1'b1;
		next_count   = count + 1'b1;
		next_tick[0] = 1'b1;
		for (int i = 1; i < STAGES; i++) begin
			carry        = carry & count[i-1];
			next_tick[i] = carry;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			count <= '0;
			tick  <= '0;
		end else begin
			count <= next_count;
			tick  <= next_tick;
		end
	end
endmodule : ubg_prescaler

// ===== core/ubg_baud_gen.sv
`timescale 1ns/10ps
`include "ubg_defines.svh"

// Function
// (R1) Bit rate is operation clock over divider plus one, halved.
// (R2) Divider comes from data register bits 15 down to 9, seven bits unsigned.
// (R3) Software writes divider only 2 to 127; zero and one forbidden.
// (R4) Operation clock chosen by mode bit 15 plus shared prescaler register.
// (R5) Select bit 0 uses low prescaler field: clock over two to p.
// (R6) Select bit 1 uses high field; low field then has no effect.
// (R7) Software stops all channels before changing system clock source.
// (R8) Receiver latches bits timed from the seven-bit divider ratio.
// (R9) Divider reloads on start, ticks every divider plus one operation clocks.
module ubg_baud_gen #(
	parameter int CHANNELS = 2
) (
	input  wire logic                 clock,
	input  wire logic                 reset_n,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	output logic      [CHANNELS-1:0]  half_bit_tick,
	output logic      [CHANNELS-1:0]  bit_tick,
	output logic      [CHANNELS-1:0]  channel_enabled
);
	localparam int STAGES = 16;

	if (CHANNELS < 1 || CHANNELS > 2) begin : g_bad_channels
		$error("ubg_baud_gen: CHANNELS must be 1 or 2");
	end

	// ==========================================
	// Registers
	logic [7:0]          prescaler_select_reg;
	logic [15:0]         channel_mode_reg [CHANNELS];
	logic [15:0]         channel_serial_data_reg [CHANNELS];
	logic [CHANNELS-1:0] enable_state;
	logic [CHANNELS-1:0] start_req;
	logic [7:0]          next_prescaler_select_reg;
	logic [15:0]         next_channel_mode_reg [CHANNELS];
	logic [15:0]         next_channel_serial_data_reg [CHANNELS];
	logic [CHANNELS-1:0] next_enable_state;
	logic [CHANNELS-1:0] next_start_req;
	logic [31:0]         next_prdata;
	logic                next_pready;
	logic                next_pslverr;
	logic                access;
	logic [STAGES-1:0]   prs_tick;

	function automatic logic [31:0] zext16(input logic [15:0] v);
		return {16'h0000, v};
	endfunction : zext16

	// Pick the enable of one channel's operation clock
	function automatic logic op_clock_en(input logic cks, input logic [7:0] prs,
	                                     input logic [STAGES-1:0] t);
		logic [3:0] sel;
		sel = cks ? prs[`UBG_PRS_HIGH_LSB +: `UBG_PRS_WIDTH]   // R6
		          : prs[`UBG_PRS_LOW_LSB +: `UBG_PRS_WIDTH];   // R5
		return t[sel];
	endfunction : op_clock_en

	ubg_prescaler #(
		.STAGES (STAGES)
	) u_prescaler (
		.clock   (clock),
		.reset_n (reset_n),
		.tick    (prs_tick)
	);

	// ==========================================
	// APB slave, one wait state
	assign access = psel && penable && !pready;

	always_comb begin
		next_prescaler_select_reg = prescaler_select_reg;
		next_enable_state         = enable_state;
		next_start_req            = '0;
		next_prdata               = 32'h0000_0000;
		next_pready               = access;
		next_pslverr              = 1'b0;
		for (int c = 0; c < CHANNELS; c++) begin
			next_channel_mode_reg[c]        = channel_mode_reg[c];
			next_channel_serial_data_reg[c] = channel_serial_data_reg[c];
		end
		if (access) begin
			if (paddr == `UBG_ADDR_PRESCALER) begin
				if (pwrite) next_prescaler_select_reg = pwdata[7:0];
				next_prdata = {24'h00_0000, prescaler_select_reg};
			end else if (paddr == `UBG_ADDR_START) begin
				if (pwrite) begin
					next_start_req    = pwdata[CHANNELS-1:0];
					next_enable_state = enable_state | pwdata[CHANNELS-1:0];
				end
			end else if (paddr == `UBG_ADDR_STOP) begin
				if (pwrite) next_enable_state = enable_state & ~pwdata[CHANNELS-1:0];
			end else if (paddr == `UBG_ADDR_ENABLE) begin
				next_prdata[CHANNELS-1:0] = enable_state;
			end else if (paddr == `UBG_ADDR_MODE0) begin
				if (pwrite) next_channel_mode_reg[0] = pwdata[15:0];
				next_prdata = zext16(channel_mode_reg[0]);
			end else if (paddr == `UBG_ADDR_MODE1 && CHANNELS > 1) begin
				if (pwrite) next_channel_mode_reg[CHANNELS-1] = pwdata[15:0];
				next_prdata = zext16(channel_mode_reg[CHANNELS-1]);
			end else if (paddr == `UBG_ADDR_DATA0) begin
				if (pwrite) next_channel_serial_data_reg[0] = pwdata[15:0];
				next_prdata = zext16(channel_serial_data_reg[0]);
			end else if (paddr == `UBG_ADDR_DATA1 && CHANNELS > 1) begin
				if (pwrite) next_channel_serial_data_reg[CHANNELS-1] = pwdata[15:0];
				next_prdata = zext16(channel_serial_data_reg[CHANNELS-1]);
			end else if (paddr == `UBG_ADDR_STATUS) begin
				next_prdata[CHANNELS-1:0] = half_bit_tick | bit_tick;
			end else begin
				// Unmapped: error response, no state change
				next_pslverr = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			prescaler_select_reg <= `UBG_RST_PRESCALER;
			enable_state         <= '0;
			start_req            <= '0;
			prdata               <= 32'h0000_0000;
			pready               <= 1'b0;
			pslverr              <= 1'b0;
			for (int c = 0; c < CHANNELS; c++) begin
				channel_mode_reg[c]        <= `UBG_RST_MODE;
				channel_serial_data_reg[c] <= `UBG_RST_DATA;
			end
		end else begin
			prescaler_select_reg <= next_prescaler_select_reg;
			enable_state         <= next_enable_state;
			start_req            <= next_start_req;
			prdata               <= next_prdata;
			pready               <= next_pready;
			pslverr              <= next_pslverr;
			for (int c = 0; c < CHANNELS; c++) begin
				channel_mode_reg[c]        <= next_channel_mode_reg[c];
				channel_serial_data_reg[c] <= next_channel_serial_data_reg[c];
			end
		end
	end

	// ==========================================
	// Per-channel baud divider
	// Forbidden divider codes are not clamped; software must avoid them
	ubg_pkg::ubg_state_t state [CHANNELS];
	ubg_pkg::ubg_state_t next_state [CHANNELS];
	logic [6:0]          div_count [CHANNELS];
	logic [6:0]          next_div_count [CHANNELS];
	logic [CHANNELS-1:0] phase;
	logic [CHANNELS-1:0] next_phase;
	logic [CHANNELS-1:0] next_half_bit_tick;
	logic [CHANNELS-1:0] next_bit_tick;

	always_comb begin
		for (int c = 0; c < CHANNELS; c++) begin
			logic [6:0] div;
			logic       en;
			div = channel_serial_data_reg[c][`UBG_DIV_MSB:`UBG_DIV_LSB];   // R2
			en  = op_clock_en(channel_mode_reg[c][`UBG_CKS_BIT],
			                  prescaler_select_reg, prs_tick);          // R4
			next_state[c]         = state[c];
			next_div_count[c]     = div_count[c];
			next_phase[c]         = phase[c];
			next_half_bit_tick[c] = 1'b0;
			next_bit_tick[c]      = 1'b0;
			case (state[c])
				ubg_pkg::UBG_IDLE: begin
					if (start_req[c]) begin
						next_state[c]     = ubg_pkg::UBG_RUN;
						next_div_count[c] = div;   // R9
						next_phase[c]     = 1'b0;
					end
				end
				ubg_pkg::UBG_RUN: begin
					if (!enable_state[c]) begin
						next_state[c] = ubg_pkg::UBG_IDLE;
					end else if (start_req[c]) begin
						next_div_count[c] = div;   // R9
						next_phase[c]     = 1'b0;
					end else if (en) begin
						if (div_count[c] == 7'h00) begin
							// Half-bit every div+1 operation clocks; two make a bit
							next_div_count[c]     = div;          // R1
							next_half_bit_tick[c] = 1'b1;         // R9
							next_bit_tick[c]      = phase[c];     // R1 R8
							next_phase[c]         = ~phase[c];
						end else begin
							next_div_count[c] = div_count[c] - 7'h01;
						end
					end
				end
				default: next_state[c] = ubg_pkg::UBG_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			phase           <= '0;
			half_bit_tick   <= '0;
			bit_tick        <= '0;
			channel_enabled <= '0;
			for (int c = 0; c < CHANNELS; c++) begin
				state[c]     <= ubg_pkg::UBG_IDLE;
				div_count[c] <= 7'h00;
			end
		end else begin
			phase           <= next_phase;
			half_bit_tick   <= next_half_bit_tick;
			bit_tick        <= next_bit_tick;
			channel_enabled <= enable_state;
			for (int c = 0; c < CHANNELS; c++) begin
				state[c]     <= next_state[c];
				div_count[c] <= next_div_count[c];
			end
		end
	end
endmodule : ubg_baud_gen

// ===== verif/ubg_baud_gen_monitor.sv
`timescale 1ns/10ps
// ==========
// Port checker
module ubg_baud_gen_monitor #(
	parameter int CHANNELS = 2
) (
	input wire logic                clock,
	input wire logic                reset_n,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [11:0]         paddr,
	input wire logic [31:0]         pwdata,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	input wire logic [CHANNELS-1:0] half_bit_tick,
	input wire logic [CHANNELS-1:0] bit_tick,
	input wire logic [CHANNELS-1:0] channel_enabled
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// ==========
	// Bus
	chk_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("bus answer late");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held");
	chk_ready_cause: assert property (pready |-> $past(psel && penable))
		else $error("ready without access");
	chk_err_unmapped: assert property (psel && penable && !pready && paddr > 12'h020 |=> pslverr && prdata == 32'h0)
		else $error("unmapped not refused");
	chk_err_mapped: assert property (psel && penable && !pready && paddr == 12'h018 |=> !pslverr)
		else $error("mapped refused");
	// ==========
	// Ticks
	chk_bit_on_half: assert property (bit_tick[0] |-> half_bit_tick[0])
		else $error("bit tick off half");
	chk_half_gap: assert property (half_bit_tick[0] |=> !half_bit_tick[0] [*2])
		else $error("half ticks too close");
	chk_bit_gap: assert property (bit_tick[0] |=> !bit_tick[0] [*5])
		else $error("bit ticks too close");
	chk_idle_quiet: assert property (!channel_enabled[0] [*2] |-> !half_bit_tick[0])
		else $error("tick while stopped");
	cover property (pready && pslverr);
	cover property (bit_tick[0]);
	cover property (bit_tick[1]);
endmodule : ubg_baud_gen_monitor

bind ubg_baud_gen ubg_baud_gen_monitor #(.CHANNELS(CHANNELS)) i_mon (.clock(clock), .reset_n(reset_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .half_bit_tick(half_bit_tick), .bit_tick(bit_tick),
	.channel_enabled(channel_enabled));

// ===== verif/ubg_remote_rx.sv
`timescale 1ns/10ps
// ==========
// Far-end receiver, latches the half-bit and bit tick periods at each boundary
module ubg_remote_rx (
	input wire logic        clock,
	input wire logic        reset_n,
	input wire logic        half_bit_tick,
	input wire logic        bit_tick,
	output logic     [31:0] half_period,
	output logic     [31:0] bit_period
);
	logic [31:0] half_cnt;
	logic [31:0] bit_cnt;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			half_cnt <= 32'h0;
			bit_cnt <= 32'h0;
			half_period <= 32'h0;
			bit_period <= 32'h0;
		end else begin
			half_cnt <= half_bit_tick ? 32'h1 : half_cnt + 32'h1;
			bit_cnt <= bit_tick ? 32'h1 : bit_cnt + 32'h1;
			if (half_bit_tick)
				half_period <= half_cnt;
			if (bit_tick)
				bit_period <= bit_cnt;
		end
	end
endmodule : ubg_remote_rx

// ===== verif/uart_baud_clock_generator_tb_top.sv
`timescale 1ns/10ps
`include "ubg_defines.svh"
module uart_baud_clock_generator_tb_top;
	logic        clock;
	logic        reset_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [1:0]  half_bit_tick;
	logic [1:0]  bit_tick;
	logic [1:0]  channel_enabled;
	logic [31:0] half_period [2];
	logic [31:0] bit_period [2];
	logic [31:0] seed = 32'hB604C73A;
	int          err_total;
	int          cmp_count;
	ubg_baud_gen #(.CHANNELS(2)) i_dut (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.half_bit_tick(half_bit_tick), .bit_tick(bit_tick), .channel_enabled(channel_enabled));
	for (genvar g = 0; g < 2; g++) begin : g_rx
		ubg_remote_rx i_rx (.clock(clock), .reset_n(reset_n), .half_bit_tick(half_bit_tick[g]),
			.bit_tick(bit_tick[g]), .half_period(half_period[g]), .bit_period(bit_period[g]));
	end
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	// System clocks per half bit: divider plus one operation clocks of 2^p each
	function automatic logic [31:0] half_exp(input logic [3:0] p, input logic [6:0] d);
		return (32'h1 + 32'(d)) << p;
	endfunction : half_exp
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = pslverr ? 32'hFFFFFFFF : prdata;
		check(32'(n < 50), 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb
	task automatic wait_bit(input int ch);
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (bit_tick[ch] !== 1'b1 && n < 3000);
		check(32'(n < 3000), 32'h1);
	endtask : wait_bit
	task automatic print_verdict();
		$display("mismatches %0d of %0d compares", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		print_verdict();
	end
	initial begin
		logic [31:0] r;
		logic [31:0] q;
		logic [3:0]  lo;
		logic [3:0]  hi;
		logic [6:0]  dv;
		logic        cks;
		int          ch;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		reset_n = 1'b0;
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		apb(0, `UBG_ADDR_MODE0, 0, q);
		check(q, 32'h20);
		apb(0, `UBG_ADDR_DATA1, 0, q);
		check(q, 32'h0);
		apb(0, 12'h024, 0, q);
		check(q, 32'hFFFFFFFF);
		for (int k = 0; k < 12; k++) begin
			r = xs();
			ch = int'(r[0]);
			cks = r[1];
			lo = {2'b0, r[3:2]};
			hi = {2'b0, r[5:4]};
			dv = 7'(r[8:6]) + 7'h2;
			if (k == 0) begin
				{ch, cks, lo, dv} = {32'h0, 1'b0, 4'h0, 7'h02};
			end
			if (k == 1) begin
				{cks, hi, lo, dv} = {1'b1, 4'h0, 4'hF, 7'h7F};
			end
			apb(1, `UBG_ADDR_PRESCALER, {24'h0, hi, lo}, q);
			apb(0, `UBG_ADDR_PRESCALER, 0, q);
			check(q, {24'h0, hi, lo});
			apb(1, 12'(`UBG_ADDR_MODE0 + 4 * ch), {16'h0, cks, 15'h0}, q);
			apb(1, 12'(`UBG_ADDR_DATA0 + 4 * ch), {16'h0, dv, 9'h0}, q);
			apb(0, 12'(`UBG_ADDR_DATA0 + 4 * ch), 0, q);
			check(q, {16'h0, dv, 9'h0});
			apb(1, `UBG_ADDR_START, 32'h1 << ch, q);
			apb(0, `UBG_ADDR_ENABLE, 0, q);
			check(q, 32'h1 << ch);
			check({30'h0, channel_enabled}, 32'h1 << ch);
			repeat (3) wait_bit(ch);
			@(negedge clock);
			check(bit_period[ch], half_exp(cks ? hi : lo, dv) << 1);
			check(half_period[ch], half_exp(cks ? hi : lo, dv));
			@(posedge clock);
			apb(1, `UBG_ADDR_STOP, 32'h3, q);
			apb(0, `UBG_ADDR_ENABLE, 0, q);
			check(q, 32'h0);
			repeat (3) @(posedge clock);
			check({30'h0, channel_enabled}, 32'h0);
		end
		print_verdict();
	end
endmodule : uart_baud_clock_generator_tb_top
